/* design/gsr_pkg.sv */
// constants and types shared by the reporting block
package gsr_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int ERR_DLY_MS = 500;
   localparam int ERR_DLY_CYC = CLK_HZ / 1000 * ERR_DLY_MS;
   localparam int REPLY_LEN = 42;
   localparam int LVL_LEN = 4;
   localparam logic [4:0] E_NONE = 5'h00;
   localparam logic [4:0] E_RPP = 5'h01;
   localparam logic [4:0] E_TRK = 5'h02;
   localparam logic [4:0] E_PAIR = 5'h03;
   localparam logic [4:0] E_CAL = 5'h06;
   localparam logic [2:0] STB_RQS = 3'h4;
   localparam logic [7:0] STB_RPP = 8'h41;
   localparam logic [8:0] TRK_MAX = 9'h0ff;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [5:0] A_LEVEL = 6'h2a;
   localparam logic [5:0] A_STATUS = 6'h2b;
   localparam logic [5:0] A_MASK = 6'h2c;
   localparam logic [5:0] A_TRACK = 6'h2d;
   localparam logic [20:0] CF_MAX_STD = 21'h07ef40;
   localparam logic [20:0] CF_MAX_EXT = 21'h0fde80;
   localparam logic [11:0] LVL_MIN = 12'hb0a;
   localparam logic [7:0] CH_COMMA = 8'h2c;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_DOT = 8'h2e;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_GT = 8'h3e;
   localparam logic [15:0] CMD_PROT_RESET = 16'h5253;

   typedef enum logic [1:0] {TK_IDLE, TK_FETCH, TK_LOAD, TK_SEND} gsr_tk_t;
   typedef enum logic [1:0] {RK_NUM, RK_LVL, RK_OFF} gsr_kind_t;

   // known two-character codes
   function automatic logic is_code(input logic [15:0] p);
      case (p)
         16'h4445, 16'h4346, 16'h464d, 16'h414d, 16'h4c56, 16'h5346,
         16'h5253, 16'h4d5a, 16'h4b5a, 16'h485a, 16'h5043, 16'h564c,
         16'h4d56, 16'h5556, 16'h4442, 16'h4d30, 16'h4d31, 16'h4d32,
         16'h4d33, 16'h4d34, 16'h4f4e, 16'h4f46, 16'h4954, 16'h5854,
         16'h5354: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
endpackage

/* design/gsr_hold_timer.sv */
// busy window started by a pulse, used for the error display delay
`timescale 1ns/1ps
`default_nettype none
module gsr_hold_timer #(
   parameter int CYC = gsr_pkg::ERR_DLY_CYC
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   output logic busy_o
);
   typedef struct packed {
      logic [31:0] cnt;
      logic busy;
   } gsr_tm_t;
   gsr_tm_t q, d;

   always_comb begin
      d = q;
      if (start_i) begin
         d.cnt = 32'(CYC - 1);
         d.busy = 1'b1;
      end else if (q.busy) begin
         if (q.cnt == 32'h0) begin
            d.busy = 1'b0;
         end else begin
            d.cnt = q.cnt - 32'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy_o = q.busy;
endmodule
`default_nettype wire

/* design/gsr_digit_mem.sv */
// digit store for the numeric talker reply, registered read
`timescale 1ns/1ps
`default_nettype none
module gsr_digit_mem #(
   parameter int DEPTH = gsr_pkg::REPLY_LEN,
   parameter int W = 4
) (
   input wire logic ref_clk_i,
   input wire logic we_i,
   input wire logic [5:0] waddr_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic [5:0] raddr_i,
   output logic [W-1:0] rdata_o
);
   logic [W-1:0] mem_q [DEPTH];

   always_ff @(posedge ref_clk_i) begin
      if (we_i && (int'(waddr_i) < DEPTH)) begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= (int'(raddr_i) < DEPTH) ? mem_q[raddr_i] : '0;
   end
endmodule
`default_nettype wire

/* design/gsr_report.sv */
// bus reporting: talker replies, errors, service request, clear
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gsr_report #(
   parameter int ERR_DLY_CYC = gsr_pkg::ERR_DLY_CYC,
   parameter bit EXTENDED = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_char_i,
   output logic rx_ready_o,
   output logic cmd_valid_o,
   output logic [15:0] cmd_o,
   output logic digit_valid_o,
   output logic [7:0] digit_o,
   input wire logic talk_i,
   input wire logic sf_mode_i,
   input wire logic off_tune_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic [7:0] tx_char_o,
   output logic tx_last_o,
   input wire logic spoll_i,
   output logic srq_o,
   output logic [7:0] poll_o,
   output logic [4:0] err_disp_o,
   output logic stall_o,
   input wire logic rpp_trip_i,
   output logic rf_isolate_o,
   input wire logic track_wr_i,
   input wire logic [8:0] track_val_i,
   output logic [7:0] track_o,
   input wire logic sf4_i,
   input wire logic key_bit_valid_i,
   input wire logic key_bit_i,
   input wire logic key_store_i,
   input wire logic dev_clear_i,
   input wire logic cal_ok_i,
   input wire logic recall10_i,
   input wire logic go_remote_i,
   input wire logic return_key_i,
   input wire logic lockout_i,
   output logic remote_o,
   output logic clear_o,
   output logic [20:0] carrier_khz_o,
   output logic [11:0] level_o,
   output logic carrier_on_o,
   output logic mod_off_o,
   output logic int_mod_o
);
   typedef struct packed {
      gsr_pkg::gsr_tk_t tk;
      gsr_pkg::gsr_kind_t kind;
      logic [5:0] idx;
      logic tx_valid;
      logic [7:0] tx_char;
      logic tx_last;
      logic pend;
      logic [7:0] pch;
      logic cmd_v;
      logic [15:0] cmd;
      logic dig_v;
      logic [7:0] dig;
      logic [7:0] mask;
      logic [7:0] mask_ed;
      logic [4:0] err;
      logic [4:0] disp;
      logic srq;
      logic [7:0] stb;
      logic [7:0] poll;
      logic stall;
      logic rx_rdy;
      logic isolate;
      logic [7:0] track;
      logic remote;
      logic boot;
      logic clr;
      logic [20:0] cf;
      logic [11:0] lvl;
      logic car_on;
      logic mod_off;
      logic int_mod;
      logic [15:0] level_disp;
      logic [15:0] rdata;
   } gsr_st_t;

   gsr_st_t q, d;
   logic t_busy;
   logic t_start;
   logic [3:0] mem_rd;

   function automatic logic [3:0] lvl_nib(input logic [15:0] v, input logic [1:0] i);
      case (i)
         2'h0: return v[15:12];
         2'h1: return v[11:8];
         2'h2: return v[7:4];
         default: return v[3:0];
      endcase
   endfunction

   gsr_hold_timer #(.CYC(ERR_DLY_CYC)) u_tmr (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .start_i(t_start),
      .busy_o(t_busy)
   );

   gsr_digit_mem #(.DEPTH(gsr_pkg::REPLY_LEN), .W(4)) u_mem (
      .ref_clk_i(ref_clk_i),
      .we_i(reg_wr_i),
      .waddr_i(reg_addr_i),
      .wdata_i(reg_wdata_i[3:0]),
      .raddr_i(q.idx),
      .rdata_o(mem_rd)
   );

   always_comb begin
      logic take, sep, isdig, good, bad, restart, clr_req, apply;
      logic go;
      logic [4:0] n;
      logic [7:0] c;
      d = q;
      c = rx_char_i;
      take = rx_valid_i && q.rx_rdy;
      sep = (c == gsr_pkg::CH_COMMA) || (c == gsr_pkg::CH_SPACE);
      isdig = ((c >= gsr_pkg::CH_0) && (c <= gsr_pkg::CH_9)) || (c == gsr_pkg::CH_DOT);
      good = 1'b0;
      bad = 1'b0;
      restart = 1'b0;
      clr_req = 1'b0;
      apply = 1'b0;
      go = 1'b0;
      n = gsr_pkg::E_NONE;
      d.cmd_v = 1'b0;
      d.dig_v = 1'b0;
      d.clr = 1'b0;
      d.boot = 1'b0;
      if (take && !sep) begin
         if (q.pend) begin
            d.pend = 1'b0;
            good = gsr_pkg::is_code({q.pch, c});
            bad = !good;
         end else if (isdig) begin
            good = 1'b1;
         end else begin
            d.pend = 1'b1;
            d.pch = c;
         end
      end
      // any valid code or digit restarts
      if (good && q.stall) begin
         restart = 1'b1;
      end else if (good && q.pend) begin
         d.cmd_v = 1'b1;
         d.cmd = {q.pch, c};
         if ({q.pch, c} == gsr_pkg::CMD_PROT_RESET) begin
            d.isolate = 1'b0;
         end
      end else if (good) begin
         d.dig_v = 1'b1;
         d.dig = c;
      end
      // power-on acts as clear unless recall
      clr_req = dev_clear_i || (q.boot && !recall10_i);
      if (clr_req && !cal_ok_i) begin
         d.stall = 1'b1;
      end else if (clr_req || restart) begin
         apply = 1'b1;
         d.stall = 1'b0;
      end
      // standard and stores not held here
      if (apply) begin
         d.clr = 1'b1;
         d.cf = EXTENDED ? gsr_pkg::CF_MAX_EXT : gsr_pkg::CF_MAX_STD;
         d.lvl = gsr_pkg::LVL_MIN;
         d.car_on = 1'b1;
         d.mod_off = 1'b1;
         d.int_mod = 1'b1;
      end
      if (track_wr_i && track_val_i <= gsr_pkg::TRK_MAX) begin
         d.track = track_val_i[7:0];
      end
      if (rpp_trip_i && !q.isolate) begin
         d.isolate = 1'b1;
         go = 1'b1;
         n = gsr_pkg::E_RPP;
      end else if (clr_req && !cal_ok_i) begin
         go = 1'b1;
         n = gsr_pkg::E_CAL;
      end else if (track_wr_i && track_val_i > gsr_pkg::TRK_MAX) begin
         go = 1'b1;
         n = gsr_pkg::E_TRK;
      end else if (bad) begin
         go = 1'b1;
         n = gsr_pkg::E_PAIR;
      end else if (talk_i && q.tk == gsr_pkg::TK_IDLE && sf_mode_i && off_tune_i) begin
         go = 1'b1;
      end
      // poll answers then drops the request
      if (spoll_i) begin
         d.poll = q.srq ? q.stb : {3'h0, q.err};
         d.srq = 1'b0;
      end
      if (go) begin
         if (n != gsr_pkg::E_NONE) begin
            d.err = n;
         end
         // mask bit n-1 suppresses the service request for error n
         if (n == gsr_pkg::E_NONE || n > 5'h08 || !q.mask[3'(n - 5'h01)]) begin
            d.srq = 1'b1;
            // status with request flag and number
            d.stb = (n == gsr_pkg::E_RPP) ? gsr_pkg::STB_RPP : {gsr_pkg::STB_RQS, n};
         end
      end
      t_start = go && (n != gsr_pkg::E_NONE);
      d.rx_rdy = !t_start && !t_busy;
      d.disp = t_busy ? q.err : gsr_pkg::E_NONE;
      if (!sf4_i) begin
         d.mask_ed = q.mask;
      end else if (key_store_i) begin
         d.mask = q.mask_ed;
      end else if (key_bit_valid_i) begin
         d.mask_ed = {q.mask_ed[6:0], key_bit_i};
      end
      if (go_remote_i) begin
         d.remote = 1'b1;
      end else if (return_key_i && !lockout_i) begin
         d.remote = 1'b0;
      end
      unique case (q.tk)
         gsr_pkg::TK_IDLE: begin
            if (talk_i) begin
               d.idx = 6'h00;
               d.tk = gsr_pkg::TK_FETCH;
               d.kind = !sf_mode_i ? gsr_pkg::RK_NUM :
                        off_tune_i ? gsr_pkg::RK_OFF : gsr_pkg::RK_LVL;
            end
         end
         gsr_pkg::TK_FETCH: d.tk = gsr_pkg::TK_LOAD;
         gsr_pkg::TK_LOAD: begin
            d.tk = gsr_pkg::TK_SEND;
            d.tx_valid = 1'b1;
            unique case (q.kind)
               gsr_pkg::RK_NUM: begin
                  d.tx_char = gsr_pkg::CH_0 + {4'h0, mem_rd};
                  d.tx_last = (q.idx == 6'(gsr_pkg::REPLY_LEN - 1));
               end
               gsr_pkg::RK_LVL: begin
                  d.tx_char = gsr_pkg::CH_0 + {4'h0, lvl_nib(q.level_disp, q.idx[1:0])};
                  d.tx_last = (q.idx == 6'(gsr_pkg::LVL_LEN - 1));
               end
               default: begin
                  d.tx_char = (q.idx == 6'h00) ? gsr_pkg::CH_0 : gsr_pkg::CH_GT;
                  d.tx_last = (q.idx == 6'(gsr_pkg::LVL_LEN - 1));
               end
            endcase
         end
         gsr_pkg::TK_SEND: begin
            if (tx_ready_i) begin
               d.tx_valid = 1'b0;
               d.tx_last = 1'b0;
               d.idx = q.idx + 6'h01;
               d.tk = q.tx_last ? gsr_pkg::TK_IDLE : gsr_pkg::TK_FETCH;
            end
         end
      endcase
      if (reg_wr_i && reg_addr_i == gsr_pkg::A_LEVEL) begin
         d.level_disp = reg_wdata_i;
      end
      d.rdata = 16'h0000;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            gsr_pkg::A_LEVEL: d.rdata = q.level_disp;
            gsr_pkg::A_STATUS: d.rdata = {4'h0, q.remote, q.isolate, q.stall, q.srq, q.stb};
            gsr_pkg::A_MASK: d.rdata = {q.mask_ed, q.mask};
            gsr_pkg::A_TRACK: d.rdata = {8'h00, q.track};
            default: d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q <= '0;
         q.boot <= 1'b1;
         q.mask <= gsr_pkg::MASK_RST;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_o = q.rdata;
   assign rx_ready_o = q.rx_rdy;
   assign cmd_valid_o = q.cmd_v;
   assign cmd_o = q.cmd;
   assign digit_valid_o = q.dig_v;
   assign digit_o = q.dig;
   assign tx_valid_o = q.tx_valid;
   assign tx_char_o = q.tx_char;
   assign tx_last_o = q.tx_last;
   assign srq_o = q.srq;
   assign poll_o = q.poll;
   assign err_disp_o = q.disp;
   assign stall_o = q.stall;
   assign rf_isolate_o = q.isolate;
   assign track_o = q.track;
   assign remote_o = q.remote;
   assign clear_o = q.clr;
   assign carrier_khz_o = q.cf;
   assign level_o = q.lvl;
   assign carrier_on_o = q.car_on;
   assign mod_off_o = q.mod_off;
   assign int_mod_o = q.int_mod;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_talk_start;
      talk_i && q.tk == gsr_pkg::TK_IDLE;
   endsequence
   sequence s_first_char;
      ##3 tx_valid_o;
   endsequence

   a_talk_first_char: assert property (
      s_talk_start |-> s_first_char) else $error("talker reply late");
   a_offtune_reply: assert property (
      s_talk_start ##0 (sf_mode_i && off_tune_i) |-> ##3 tx_char_o == gsr_pkg::CH_0)
      else $error("off tune reply wrong");
   a_poll_status: assert property (
      spoll_i && srq_o |=> poll_o == $past(q.stb) && poll_o[7:6] != 2'b00)
      else $error("poll status wrong");
   a_rx_withheld: assert property (
      t_busy && $past(t_busy) |-> !rx_ready_o) else $error("handshake during error display");
   a_trip_isolate: assert property (
      rpp_trip_i && !rf_isolate_o |=> rf_isolate_o) else $error("trip did not isolate");
   a_trip_status: assert property (
      rpp_trip_i && !rf_isolate_o && !q.mask[0] |=> srq_o && q.stb == gsr_pkg::STB_RPP)
      else $error("trip status not 65");
   a_track_kept: assert property (
      track_wr_i && track_val_i > gsr_pkg::TRK_MAX |=> track_o == $past(track_o))
      else $error("tracking over limit stored");
   a_mask_store: assert property (
      sf4_i && key_store_i |=> q.mask == $past(q.mask_ed)) else $error("mask store lost");
   a_return_key: assert property (
      return_key_i && !go_remote_i |=> remote_o == ($past(remote_o) && $past(lockout_i)))
      else $error("return key misapplied");
endmodule
`default_nettype wire

/* verification/gsr_ctl_model.sv */
// bus controller model: command bytes, talker bytes, serial poll
`timescale 1ns/1ps
`default_nettype none
module gsr_ctl_model (
   input wire logic ref_clk_i,
   output logic rx_valid_o,
   output logic [7:0] rx_char_o,
   input wire logic rx_ready_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_char_i,
   input wire logic tx_last_i,
   output logic tx_ready_o,
   output logic spoll_o,
   input wire logic [7:0] poll_i
);
   logic [7:0] got [$];
   logic slow = 1'b0;
   logic ph = 1'b0;
   int last_n = 0;
   initial begin
      rx_valid_o = 1'b0;
      rx_char_o = 8'h00;
      tx_ready_o = 1'b0;
      spoll_o = 1'b0;
   end
   // acceptor side, every other cycle when slow
   always @(posedge ref_clk_i) begin
      ph <= ~ph;
      tx_ready_o <= !slow || ph;
      if (tx_valid_i && tx_ready_o) begin
         got.push_back(tx_char_i);
         if (tx_last_i) last_n = got.size();
      end
   end
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         rx_valid_o <= 1'b1;
         rx_char_o <= s[i];
         @(posedge ref_clk_i);
         while (!rx_ready_i) @(posedge ref_clk_i);
      end
      rx_valid_o <= 1'b0;
      rx_char_o <= ~s[s.len()-1];
   endtask
   task automatic poll(output logic [7:0] stb);
      spoll_o <= 1'b1;
      @(posedge ref_clk_i);
      spoll_o <= 1'b0;
      @(posedge ref_clk_i);
      stb = poll_i;
   endtask
endmodule
`default_nettype wire

/* verification/gsr_report_test.sv */
// self-checking bench for the bus reporting block
`timescale 1ns/1ps
`default_nettype none
module gsr_report_test;
   logic ref_clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic sf_mode_i = 1'b0, off_tune_i = 1'b0, sf4_i = 1'b0, key_bit_i = 1'b0;
   logic cal_ok_i = 1'b1, lockout_i = 1'b0;
   logic [5:0] reg_addr_i = 6'h00;
   logic [15:0] reg_wdata_i = 16'h0000, rdat, reg_rdata_o, cmd_o;
   logic [7:0] pl = 8'h00, stb, rx_char, tx_char_o, poll_o, digit_o, track_o;
   logic [8:0] track_val_i = 9'h000;
   logic rx_valid, rx_ready_o, cmd_valid_o, digit_valid_o, tx_ready, tx_valid_o;
   logic tx_last_o, spoll, srq_o, stall_o, rf_isolate_o, remote_o, clear_o;
   logic carrier_on_o, mod_off_o, int_mod_o;
   logic [4:0] err_disp_o;
   logic [20:0] carrier_khz_o;
   logic [11:0] level_o;
   logic [15:0] cmds [$];
   int errors = 0, cmp_count = 0, cyc = 0, clr_cnt = 0, n, m;
   logic recall10 = 1'b0;
   logic [23:0] digs = 24'h000000;

   always #12.5 ref_clk_i = ~ref_clk_i;

   gsr_report #(.ERR_DLY_CYC(20)) u_dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .rx_valid_i(rx_valid), .rx_char_i(rx_char),
      .rx_ready_o(rx_ready_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o),
      .digit_valid_o(digit_valid_o), .digit_o(digit_o), .talk_i(pl[0]),
      .sf_mode_i(sf_mode_i), .off_tune_i(off_tune_i), .tx_ready_i(tx_ready),
      .tx_valid_o(tx_valid_o), .tx_char_o(tx_char_o), .tx_last_o(tx_last_o),
      .spoll_i(spoll), .srq_o(srq_o), .poll_o(poll_o), .err_disp_o(err_disp_o),
      .stall_o(stall_o), .rpp_trip_i(pl[1]), .rf_isolate_o(rf_isolate_o),
      .track_wr_i(pl[2]), .track_val_i(track_val_i), .track_o(track_o),
      .sf4_i(sf4_i), .key_bit_valid_i(pl[3]), .key_bit_i(key_bit_i),
      .key_store_i(pl[4]), .dev_clear_i(pl[5]), .cal_ok_i(cal_ok_i),
      .recall10_i(recall10), .go_remote_i(pl[6]), .return_key_i(pl[7]),
      .lockout_i(lockout_i), .remote_o(remote_o), .clear_o(clear_o),
      .carrier_khz_o(carrier_khz_o), .level_o(level_o), .carrier_on_o(carrier_on_o),
      .mod_off_o(mod_off_o), .int_mod_o(int_mod_o));

   gsr_ctl_model u_ctl (
      .ref_clk_i(ref_clk_i), .rx_valid_o(rx_valid), .rx_char_o(rx_char),
      .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_char_i(tx_char_o),
      .tx_last_i(tx_last_o), .tx_ready_o(tx_ready), .spoll_o(spoll), .poll_i(poll_o));

   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (clear_o === 1'b1) clr_cnt <= clr_cnt + 1;
      if (cmd_valid_o === 1'b1) cmds.push_back(cmd_o);
      if (digit_valid_o === 1'b1) digs <= {digs[15:0], digit_o};
      if (cyc == 6000) begin
         errors++;
         close_out();
      end
   end

   task automatic close_out();
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk_i);
   endtask

   // one-cycle strobe on a bit of pl, response visible on return
   task automatic pulse(input int b);
      pl[b] <= 1'b1;
      tick(1);
      pl[b] <= 1'b0;
      tick(1);
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      tick(1);
      reg_wr_i <= 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      tick(1);
      reg_rd_i <= 1'b0;
      tick(1);
      d = reg_rdata_o;
   endtask

   task automatic talk(input string s);
      u_ctl.got.delete();
      pulse(0);
      while (u_ctl.got.size() < s.len()) tick(1);
      tick(6);
      chk("tx_count", s.len(), u_ctl.got.size());
      for (int i = 0; i < s.len(); i++) chk("tx_char", s[i], u_ctl.got[i]);
      chk("tx_last", s.len(), u_ctl.last_n);
   endtask

   task automatic poll_chk(input logic [7:0] e);
      u_ctl.poll(stb);
      chk("status", e, stb);
      tick(1);
      chk("srq_after_poll", 1'b0, srq_o);
   endtask

   task automatic track(input logic [8:0] v);
      track_val_i <= v;
      pulse(2);
   endtask

   initial begin
      tick(5);
      reset_i <= 1'b0;
      tick(6);
      chk("boot_clear", 1, clr_cnt);
      chk("carrier", gsr_pkg::CF_MAX_STD, carrier_khz_o);
      chk("level", gsr_pkg::LVL_MIN, level_o);
      chk("modes", 3'b111, {carrier_on_o, mod_off_o, int_mod_o});
      rd(gsr_pkg::A_MASK, rdat);
      chk("mask_boot", gsr_pkg::MASK_RST, rdat[7:0]);
      rd(6'h3f, rdat);
      chk("unmapped", 16'h0000, rdat);
      for (int i = 0; i < 42; i++) wr(6'(i), 16'(i % 10));
      u_ctl.slow <= 1'b1;
      talk("012345678901234567890123456789012345678901");
      u_ctl.slow <= 1'b0;
      wr(gsr_pkg::A_LEVEL, 16'h1234);
      sf_mode_i <= 1'b1;
      talk("1234");
      off_tune_i <= 1'b1;
      talk("0>>>");
      chk("srq_off_tune", 1'b1, srq_o);
      poll_chk(8'h80);
      sf_mode_i <= 1'b0;
      off_tune_i <= 1'b0;
      track(9'h0ff);
      chk("track_max", 8'hff, track_o);
      track(9'h100);
      chk("track_kept", 8'hff, track_o);
      poll_chk(8'h82);
      pulse(1);
      chk("isolate", 1'b1, rf_isolate_o);
      chk("srq_trip", 1'b1, srq_o);
      chk("hold_off", 1'b0, rx_ready_o);
      tick(1);
      chk("err_shown", gsr_pkg::E_RPP, err_disp_o);
      poll_chk(gsr_pkg::STB_RPP);
      u_ctl.send("RS");
      tick(3);
      chk("rearmed", 1'b0, rf_isolate_o);
      chk("cmd_rs", gsr_pkg::CMD_PROT_RESET, cmds[$]);
      n = cmds.size();
      u_ctl.send("Q,CF,MO,N");
      tick(3);
      chk("pair_count", n + 2, cmds.size());
      chk("pair_fm", 16'h464d, cmds[$-1]);
      chk("pair_on", 16'h4f4e, cmds[$]);
      poll_chk(8'h83);
      u_ctl.send("LV 1.2");
      tick(3);
      chk("cmd_lv", 16'h4c56, cmds[$]);
      chk("digits", 24'h312e32, digs);
      sf4_i <= 1'b1;
      key_bit_i <= 1'b1;
      pulse(3);
      pulse(3);
      rd(gsr_pkg::A_MASK, rdat);
      chk("mask_unstored", 8'h00, rdat[7:0]);
      pulse(4);
      rd(gsr_pkg::A_MASK, rdat);
      chk("mask_stored", 8'h03, rdat[7:0]);
      sf4_i <= 1'b0;
      track(9'h1ff);
      tick(1);
      chk("srq_masked", 1'b0, srq_o);
      tick(25);
      cal_ok_i <= 1'b0;
      n = clr_cnt;
      pulse(5);
      chk("stall", 1'b1, stall_o);
      chk("no_clear", n, clr_cnt);
      poll_chk(8'h86);
      cal_ok_i <= 1'b1;
      m = cmds.size();
      u_ctl.send("CF");
      tick(3);
      chk("restart_eaten", m, cmds.size());
      chk("stall_end", 1'b0, stall_o);
      chk("late_clear", n + 1, clr_cnt);
      pulse(6);
      lockout_i <= 1'b1;
      pulse(7);
      chk("locked", 1'b1, remote_o);
      lockout_i <= 1'b0;
      pulse(7);
      chk("local", 1'b0, remote_o);
      recall10 <= 1'b1;
      reset_i <= 1'b1;
      tick(2);
      reset_i <= 1'b0;
      n = clr_cnt;
      tick(4);
      chk("recall_no_clear", n, clr_cnt);
      chk("ready_after_reset", 1'b1, rx_ready_o);
      rd(gsr_pkg::A_MASK, rdat);
      chk("mask_reset", gsr_pkg::MASK_RST, rdat[7:0]);
      close_out();
   end
endmodule
`default_nettype wire
